// *** core/rnc_pkg.sv ***
// package: constants and carrier types for the reset and nmi control block
package rnc_pkg;
  // clock period in ns at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  // least low time of the reset input that is taken as a reset, in ns
  localparam int RESET_MIN_NS = 100;
  // extra clock cycles added on top of the least time
  localparam int RESET_MIN_EXTRA_CYC = 2;
  // least time rounds up to whole cycles
  localparam int RESET_QUAL_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + RESET_MIN_EXTRA_CYC;
  // default length of the internal reset sequence in clock cycles
  localparam int RESET_SEQ_CYC = 1024;
  localparam int CNT_W = 16;

  // reset source indication flags
  typedef struct packed {
    logic long_hw;
    logic short_hw;
    logic software;
    logic watchdog;
  } rnc_src_t;

  // instruction strobes from the cpu core
  typedef struct packed {
    logic end_of_init_instr;
    logic power_down_instr;
  } rnc_instr_t;

  localparam rnc_src_t SRC_NONE = 4'h0;
endpackage

// *** core/rnc_reset_nmi_ctrl.sv ***
// reset and non-maskable interrupt control: qualification, sequence, nmi
module rnc_reset_nmi_ctrl import rnc_pkg::*; #(
  parameter int SEQ_CYC = RESET_SEQ_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reset_in_n_i,
  input wire logic nmi_n_i,
  input wire logic sw_reset_i,
  input wire logic watchdog_reset_source_i,
  input wire rnc_instr_t instr_i,
  input wire logic bidir_reset_enable_wr_i,
  input wire logic bidir_reset_enable_val_i,
  output logic reset_in_n_o,
  output logic reset_in_n_oe_n_o,
  output logic reset_indicate_out_n_o,
  output logic internal_reset_o,
  output logic nmi_trap_o,
  output logic power_down_o,
  output logic bidir_reset_enable_o,
  output rnc_src_t reset_src_o
);

  localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYC - 1);
  localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(RESET_QUAL_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic rin_meta;
  logic rin_sync;
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_prev;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rin_meta <= 1'b1;
      rin_sync <= 1'b1;
      nmi_meta <= 1'b1;
      nmi_sync <= 1'b1;
      nmi_prev <= 1'b1;
    end else begin
      rin_meta <= reset_in_n_i;
      rin_sync <= rin_meta;
      nmi_meta <= nmi_n_i;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset input qualification
  // low time is counted so short glitches do not reset the part
  logic [CNT_W-1:0] qual_cnt;
  logic hw_reset;
  logic hw_long;

  // while the device itself pulls the line, the low level is its own echo
  logic line_own;
  assign line_own = !reset_in_n_oe_n_o;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      qual_cnt <= '0;
    end else if (rin_sync || line_own) begin
      qual_cnt <= '0;
    end else if (qual_cnt != QUAL_LAST) begin
      qual_cnt <= qual_cnt + CNT_W'(1);
    end
  end

  // reset once the low level has lasted the least time plus the extra cycles
  assign hw_reset = !rin_sync && !line_own && (qual_cnt == QUAL_LAST);
  // level still low at the end of the sequence counts as a long reset
  assign hw_long = !rin_sync && !line_own;

  ////////////////////////////////////////////////////////////////////////////
  // internal reset sequence
  logic [CNT_W-1:0] seq_cnt;
  logic in_seq;
  logic any_src;
  assign any_src = hw_reset || sw_reset_i || watchdog_reset_source_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_cnt <= '0;
      in_seq <= 1'b1;
    end else if (any_src) begin
      seq_cnt <= '0;
      in_seq <= 1'b1;
    end else if (in_seq) begin
      // a short reset still runs the full count, stretched
      if (seq_cnt == SEQ_LAST) begin
        in_seq <= 1'b0;
      end else begin
        seq_cnt <= seq_cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      internal_reset_o <= 1'b1;
    end else begin
      internal_reset_o <= in_seq || any_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bidirectional reset enable, cleared by reset and locked after init
  logic init_done;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      init_done <= 1'b0;
    end else if (in_seq || any_src) begin
      init_done <= 1'b0;
    end else if (instr_i.end_of_init_instr) begin
      init_done <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_reset_enable_o <= 1'b0;
    end else if (any_src) begin
      bidir_reset_enable_o <= 1'b0;
    end else if (bidir_reset_enable_wr_i && !init_done && !in_seq) begin
      bidir_reset_enable_o <= bidir_reset_enable_val_i;
    end
  end

  // enable is cleared by the reset itself, so remember it for the sequence
  logic bidir_active;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bidir_active <= 1'b0;
    end else if (any_src) begin
      bidir_active <= bidir_active || bidir_reset_enable_o;
    end else if (!in_seq) begin
      bidir_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset line drive and indication output
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_in_n_o <= 1'b0;
      reset_in_n_oe_n_o <= 1'b1;
    end else begin
      reset_in_n_o <= 1'b0;
      // in bidirectional mode, pull the line low for the whole sequence
      reset_in_n_oe_n_o <= !((any_src && (bidir_reset_enable_o ||
        bidir_active)) || (in_seq && bidir_active));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_indicate_out_n_o <= 1'b0;
    end else if (any_src || in_seq) begin
      reset_indicate_out_n_o <= 1'b0;
    end else if (instr_i.end_of_init_instr) begin
      reset_indicate_out_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset source flags
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_src_o <= SRC_NONE;
    end else if (bidir_active && in_seq && !any_src) begin
      reset_src_o <= '{long_hw: 1'b1, default: 1'b0};
    end else if (in_seq && !any_src && seq_cnt == SEQ_LAST) begin
      if (reset_src_o.short_hw && hw_long) begin
        reset_src_o <= '{long_hw: 1'b1, default: 1'b0};
      end
    end else if (any_src) begin
      reset_src_o.long_hw <= 1'b0;
      reset_src_o.short_hw <= hw_reset;
      reset_src_o.software <= sw_reset_i;
      reset_src_o.watchdog <= watchdog_reset_source_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nmi trap and power-down decision
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_trap_o <= 1'b0;
    end else begin
      nmi_trap_o <= nmi_prev && !nmi_sync && !in_seq;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      power_down_o <= 1'b0;
    end else if (any_src) begin
      power_down_o <= 1'b0;
    end else if (instr_i.power_down_instr && !in_seq) begin
      // high nmi leaves the part running
      power_down_o <= !nmi_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_trap_on_fall: assert property (@(posedge mclk_i)
    disable iff (rst_i) ($fell(nmi_sync) && !in_seq) |=> nmi_trap_o)
    else $error("nmi fall gave no trap");

  chk_trap_single: assert property (@(posedge mclk_i)
    disable iff (rst_i) nmi_trap_o |=> !nmi_trap_o)
    else $error("nmi trap longer than one cycle");

  chk_pdn_nmi_low: assert property (@(posedge mclk_i)
    disable iff (rst_i) (instr_i.power_down_instr && !in_seq && !any_src
    && !nmi_sync) |=> power_down_o)
    else $error("power-down not entered with nmi low");

  chk_pdn_nmi_high: assert property (@(posedge mclk_i)
    disable iff (rst_i) (instr_i.power_down_instr && !in_seq && !any_src
    && nmi_sync && !power_down_o) |=> !power_down_o)
    else $error("power-down taken with nmi high");

  chk_ind_in_reset: assert property (@(posedge mclk_i)
    disable iff (rst_i) (any_src || in_seq) |=> !reset_indicate_out_n_o)
    else $error("reset indication high during reset");

  chk_ind_release: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    $rose(reset_indicate_out_n_o) |-> $past(instr_i.end_of_init_instr))
    else $error("reset indication rose without end of init");

  chk_bidir_lock: assert property (@(posedge mclk_i)
    disable iff (rst_i)
    (init_done && !any_src) |=> $stable(bidir_reset_enable_o))
    else $error("bidirectional enable changed after init");

  chk_bidir_clear: assert property (@(posedge mclk_i)
    disable iff (rst_i) any_src |=> !bidir_reset_enable_o)
    else $error("bidirectional enable not cleared by reset");

  chk_bidir_drive: assert property (@(posedge mclk_i)
    disable iff (rst_i) (bidir_active && in_seq) |=> !reset_in_n_oe_n_o)
    else $error("reset line not driven in bidirectional sequence");

  chk_seq_length: assert property (@(posedge mclk_i)
    disable iff (rst_i) (any_src ##1 !any_src [*8]) |-> in_seq)
    else $error("reset sequence ended too early");

  chk_long_flag: assert property (@(posedge mclk_i)
    disable iff (rst_i) (bidir_active && in_seq && !any_src)
    |=> reset_src_o.long_hw)
    else $error("long reset flag not set in bidirectional mode");

  chk_hw_enter: assert property (@(posedge mclk_i)
    disable iff (rst_i) hw_reset |=> internal_reset_o)
    else $error("qualified reset input did not reset");

endmodule

// *** tb/rnc_partner.sv ***
// partner model: reset supervisor on an open-drain line and nmi source
module rnc_partner (
  input wire logic hold_low_i,
  input wire logic nmi_lvl_i,
  input wire logic dev_val_i,
  input wire logic dev_oe_n_i,
  output logic reset_pin_o,
  output logic nmi_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // the supervisor only pulls low; the pull-up wins when nobody pulls
  assign reset_pin_o =
    (hold_low_i || (!dev_oe_n_i && !dev_val_i)) ? 1'b0 : 1'b1;
  // nmi idles high, as an unused input would through its pull-up
  assign nmi_pin_o = nmi_lvl_i;
endmodule

// *** tb/testbench.sv ***
// testbench: reset qualification, bidirectional drive, nmi and power-down
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rnc_pkg::*;
  localparam int SEQ = 16;
  // power-on low time of the reset pin, about 1 ms at 20 ns
  localparam int PON_CYC = 50000;
  // the supervisor holds the pin low from power-on
  logic mclk_i = 0, rst_i = 1, hold = 1, nmi = 1, sw = 0, wd = 0;
  logic wr = 0, wval = 0, pin, nmi_pin, pval, oe_n, ind_n, irst;
  logic trap, pd, en;
  rnc_instr_t instr = '0;
  rnc_src_t src;
  int fails = 0, cmp_count = 0, seed = 95, n, len;
  always #10 mclk_i = ~mclk_i;
  rnc_partner PTN (.hold_low_i(hold), .nmi_lvl_i(nmi), .dev_val_i(pval),
    .dev_oe_n_i(oe_n), .reset_pin_o(pin), .nmi_pin_o(nmi_pin));
  rnc_reset_nmi_ctrl #(.SEQ_CYC(SEQ)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .reset_in_n_i(pin), .nmi_n_i(nmi_pin), .sw_reset_i(sw),
    .watchdog_reset_source_i(wd), .instr_i(instr),
    .bidir_reset_enable_wr_i(wr), .bidir_reset_enable_val_i(wval),
    .reset_in_n_o(pval), .reset_in_n_oe_n_o(oe_n),
    .reset_indicate_out_n_o(ind_n), .internal_reset_o(irst),
    .nmi_trap_o(trap), .power_down_o(pd), .bidir_reset_enable_o(en),
    .reset_src_o(src));
  ////////////////////////////////////////////////////////////////////////////
  // flag model: 0 long hw, 1 short hw, 2 software, 3 watchdog
  function automatic logic [3:0] exp_src(input int kind, input bit bidir);
    if (bidir) begin
      return 4'h8;
    end
    return 4'h8 >> kind;
  endfunction
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(ref logic s, input int k);
    s = 1'b1;
    tick(k);
    s = 1'b0;
    tick(1);
  endtask
  // bounded wait for the end of the internal reset sequence
  task automatic seq_len(output int cnt);
    cnt = 0;
    while (irst === 1'b1 && cnt < 200) begin
      tick(1);
      cnt++;
    end
    if (cnt >= 200) begin
      fails++;
      summarize();
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst_i = 1'b0;
    chk(ind_n, 1'b0);
    tick(PON_CYC - 10);
    chk(irst, 1'b1);
    hold = 1'b0; // released only after the long power-on hold
    seq_len(n);
    chk(n >= SEQ, 1'b1);
    tick(3);
    chk(ind_n, 1'b0);
    wval = 1'b1;
    pulse(wr, 1);
    chk(en, 1'b1);
    instr.end_of_init_instr = 1'b1;
    tick(1);
    instr = '0;
    tick(1);
    chk(ind_n, 1'b1);
    wval = 1'b0;
    pulse(wr, 1);
    chk(en, 1'b1);
    nmi = 1'b0;
    n = 0;
    repeat (8) begin
      tick(1);
      n += int'(trap);
    end
    chk(4'(n), 4'h1);
    nmi = 1'b1;
    tick(4);
    instr.power_down_instr = 1'b1;
    tick(1);
    instr = '0;
    tick(1);
    chk(pd, 1'b0);
    nmi = 1'b0;
    tick(6);
    instr.power_down_instr = 1'b1;
    tick(1);
    instr = '0;
    tick(1);
    chk(pd, 1'b1);
    pulse(sw, 1);
    chk(irst, 1'b1);
    chk(pin, 1'b0);
    chk(src, exp_src(2, 1));
    seq_len(n);
    chk(n >= SEQ - 2, 1'b1);
    tick(2);
    chk(pin, 1'b1);
    chk(en, 1'b0);
    nmi = 1'b1;
    wval = 1'b1;
    pulse(wr, 1);
    chk(en, 1'b1);
    // random pulse long enough to qualify but short of the sequence
    len = 10 + ($unsigned($random(seed)) % 4);
    pulse(hold, len);
    chk(pin, 1'b0);
    seq_len(n);
    chk(n >= SEQ - 4, 1'b1);
    chk(src, exp_src(0, 1));
    tick(2);
    pulse(hold, 3);
    tick(12);
    chk(irst, 1'b0);
    pulse(wd, 1);
    chk(irst, 1'b1);
    chk(oe_n, 1'b1);
    chk(src, exp_src(3, 0));
    seq_len(n);
    summarize();
  end
endmodule
